// File: acir_pkg.sv
// acir_pkg: register indices, field positions and reset values of the indexed register bank.
// assumes an APB host; each 8-bit register takes one aligned 32-bit word.
package acir_pkg;
    localparam logic [7:0] idx_status = 8'h0b;
    localparam logic [7:0] idx_test_sel = 8'h0c;
    localparam logic [7:0] idx_pnp = 8'h0d;
    localparam logic [7:0] idx_csn = 8'h0e;
    localparam logic [7:0] idx_rdport = 8'h0f;
    localparam logic [7:0] idx_volume = 8'h10;
    localparam logic [7:0] idx_eeprom = 8'h11;
    localparam logic [7:0] idx_strap = 8'h12;
    localparam logic [7:0] idx_fm = 8'h13;
    localparam logic [7:0] idx_gpio = 8'h14;
    localparam logic [7:0] idx_sa_route = 8'h15;
    localparam logic [7:0] idx_sa_format = 8'h16;
    localparam logic [7:0] idx_dp_reset = 8'h0a;
    localparam int num_regs = 32;
    localparam logic [7:0] rst_zero = 8'h00;
    // writable masks, reserved bits never store
    localparam logic [7:0] mask_dp_reset = 8'hc0;
    localparam logic [7:0] mask_volume = 8'h4b;
    localparam logic [7:0] mask_eeprom = 8'hf0;
    localparam logic [7:0] mask_fm = 8'he7;
    localparam logic [7:0] mask_sa_format = 8'hfe;
    localparam int vol_up_bit = 5;
    localparam int vol_dn_bit = 4;
    localparam int vol_ist_bit = 2;
    localparam int vol_ien_bit = 6;
    localparam int ee_cap_bit = 2;
    localparam int pnp_set_bit = 1;
    localparam int modem_cap_bit = 7;
    localparam int serial_en_bit = 6;
    localparam int strap_bit = 4;
    // chip revision value is arbitrary
    localparam logic [3:0] revision_code = 4'h3;
endpackage

// File: acir_flag.sv
// acir_flag: sticky event flag with clear-on-read; a new event beats the clear.
// assumes single clock mclk and synchronous reset.
`timescale 1ns/1ps
module acir_flag (
    input wire logic mclk,
    input wire logic rst,
    input wire logic set,
    input wire logic clr,
    output logic flag
);
    typedef struct packed {logic f;} acir_flag_t;
    acir_flag_t st, next_st;
    always_comb begin
        next_st = st;
        if (clr) next_st.f = 1'b0;
        if (set) next_st.f = 1'b1;
    end
    always_ff @(posedge mclk) begin
        if (rst) st <= '0;
        else st <= next_st;
    end
    assign flag = st.f;
endmodule

// File: acir_regs.sv
// acir_regs: indexed control/status bank of an audio controller on APB.
// assumes datapath, pnp and button logic outside feed the status inputs.
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - writing 1 to playback/capture reset bits clears that data path.
// - read-only status shows DMA, interrupt pending and FIFO empty flags.
// - pnp status reads 1 once a card select number is assigned.
// - pnp status shows four state bits and logical device enables.
// - volume up/down flags set on button press, clear on read.
// - button interrupt enable bit and clear-on-read status bit.
// - eeprom control bits drive write enable, select, clock, data directly.
// - eeprom capability reads 1 enabled; writing 0 enables.
// - pnp setting reads 0 enabled; writing 1 enables.
// - modem capability reads 1 enabled; writing 0 enables.
// - strap bit shows sampled config pin; 1 is motherboard variant.
// - ide interrupt passes through when enabled; fm and bass enables.
// - four gpio direction bits; pin select bits for gpio 2 and 3.
// - dual playback select assigns second dma to capture or playback.
// - capture source: converter when 0, serial input when 1.
// - aux converter source: fm, serial input or second dma.
// - main converter source: dma playback or serial input.
// - serial port reset bit and test mode bit.
// - slot position: last 16 bits or first 16/17 bits.
// - bit clocks per frame: 32 or more, delay or pulse mode.
// - clock and frame sync polarity invert when 0.
// - pulse frame mode enabled when bit is 1.
module acir_regs (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] dp_status,
    input wire logic csn_assigned,
    input wire logic [7:0] csn_value,
    input wire logic [7:0] read_port,
    input wire logic [3:0] pnp_state,
    input wire logic [2:0] ldev_enable,
    input wire logic vol_up_press,
    input wire logic vol_dn_press,
    input wire logic strap_pin,
    input wire logic ide_irq_in,
    input wire logic [3:0] gpio_in,
    output logic playback_clear,
    output logic capture_clear,
    output logic [3:0] test_sel,
    output logic vol_irq,
    output logic master_mute,
    output logic [1:0] vol_irq_select,
    output logic ee_write_en,
    output logic ee_cs,
    output logic ee_clk,
    output logic ee_din,
    output logic ee_capable,
    output logic pnp_enabled,
    output logic modem_capable,
    output logic serial_port_en,
    output logic ide_irq_out,
    output logic hi_byte_oe_en,
    output logic irq34_en,
    output logic bass_en,
    output logic fm_enhanced,
    output logic fm_external,
    output logic [3:0] gpio_oe,
    output logic gpio3_alt_pin,
    output logic gpio2_alt_pin,
    output logic [1:0] shift_clock_select,
    output logic [1:0] sao_source,
    output logic dual_playback_select,
    output logic capture_source_select,
    output logic aux_converter_source_select,
    output logic main_converter_source_select,
    output logic [1:0] aux_source,
    output logic serial_port_reset,
    output logic serial_port_test,
    output logic slot_position_select,
    output logic bit_clocks_per_frame,
    output logic sclk_invert,
    output logic frame_sync_invert,
    output logic pulse_frame_mode
);
    import acir_pkg::*;

    typedef struct packed {
        logic [7:0] dp_reset;
        logic [7:0] test_sel;
        logic [7:0] volume;
        logic [7:0] eeprom;
        logic ee_cap_off;
        logic pnp_on;
        logic modem_off;
        logic serial_en;
        logic strap;
        logic strap_taken;
        logic [7:0] fm;
        logic [7:0] gpio;
        logic [7:0] sa_route;
        logic [7:0] sa_format;
        logic rd_wait;
        logic [31:0] rdata;
    } acir_state_t;

    acir_state_t st, next_st;
    logic wr_en, rd_en;
    logic [7:0] idx;
    logic [7:0] wb;
    logic [7:0] rd_byte;
    logic up_flag, dn_flag, ist_flag;
    logic rd_volume;
    logic rd_load;

    // writes finish in their first access cycle; reads take one wait state so that
    // the registered read data already stands when pready is sampled high
    assign pready = !(rd_en && !st.rd_wait);
    assign pslverr = 1'b0;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign rd_load = rd_en && !st.rd_wait;
    assign idx = {2'b00, paddr[7:2]};
    assign wb = pwdata[7:0];
    // flags clear at the edge that captures them, so no press is lost unseen
    assign rd_volume = rd_load && (idx == idx_volume);

    acir_flag u_up (.mclk(mclk), .rst(rst), .set(vol_up_press), .clr(rd_volume),
        .flag(up_flag));
    acir_flag u_dn (.mclk(mclk), .rst(rst), .set(vol_dn_press), .clr(rd_volume),
        .flag(dn_flag));
    acir_flag u_ist (.mclk(mclk), .rst(rst),
        .set((vol_up_press || vol_dn_press) && st.volume[vol_ien_bit]),
        .clr(rd_volume), .flag(ist_flag));

    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            idx_dp_reset: rd_byte = st.dp_reset;
            idx_status: rd_byte = dp_status;
            idx_pnp: rd_byte = {csn_assigned, ldev_enable, pnp_state};
            idx_csn: rd_byte = csn_value;
            idx_rdport: rd_byte = read_port;
            idx_volume: rd_byte = {1'b0, st.volume[vol_ien_bit], up_flag, dn_flag,
                st.volume[3], ist_flag, st.volume[1:0]};
            idx_eeprom: rd_byte = {st.eeprom[7:4], 1'b0, !st.ee_cap_off,
                !st.pnp_on, 1'b0};
            idx_strap: rd_byte = {!st.modem_off, st.serial_en, 1'b0, st.strap,
                revision_code};
            idx_fm: rd_byte = st.fm;
            idx_gpio: rd_byte = st.gpio;
            idx_sa_route: rd_byte = st.sa_route;
            idx_sa_format: rd_byte = st.sa_format;
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        next_st = st;
        // strap caught on the first edge after reset release, never under reset
        if (!st.strap_taken) begin
            next_st.strap = strap_pin;
            next_st.strap_taken = 1'b1;
        end
        if (rd_load) next_st.rdata = {24'h000000, rd_byte};
        next_st.rd_wait = rd_load;
        if (wr_en) begin
            case (idx)
                idx_dp_reset: next_st.dp_reset = wb & mask_dp_reset;
                idx_test_sel: next_st.test_sel = wb;
                idx_volume: next_st.volume = wb & mask_volume;
                idx_eeprom: begin
                    next_st.eeprom = wb & mask_eeprom;
                    next_st.ee_cap_off = wb[ee_cap_bit];
                    next_st.pnp_on = wb[pnp_set_bit];
                end
                idx_strap: begin
                    next_st.modem_off = wb[modem_cap_bit];
                    next_st.serial_en = wb[serial_en_bit];
                end
                idx_fm: next_st.fm = wb & mask_fm;
                idx_gpio: next_st.gpio = wb;
                idx_sa_route: next_st.sa_route = wb;
                idx_sa_format: next_st.sa_format = wb & mask_sa_format;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign playback_clear = st.dp_reset[7];
    assign capture_clear = st.dp_reset[6];
    assign test_sel = st.test_sel[3:0];
    assign vol_irq = ist_flag;
    assign master_mute = st.volume[3];
    assign vol_irq_select = st.volume[1:0];
    assign ee_write_en = st.eeprom[7];
    assign ee_cs = st.eeprom[6];
    assign ee_clk = st.eeprom[5];
    assign ee_din = st.eeprom[4];
    assign ee_capable = !st.ee_cap_off;
    assign pnp_enabled = st.pnp_on;
    assign modem_capable = !st.modem_off;
    assign serial_port_en = st.serial_en;
    assign ide_irq_out = st.fm[7] && ide_irq_in;
    assign hi_byte_oe_en = st.fm[6];
    assign irq34_en = st.fm[5];
    assign bass_en = st.fm[2];
    assign fm_enhanced = st.fm[1];
    assign fm_external = st.fm[0];
    assign gpio_oe = {st.gpio[6], st.gpio[4], st.gpio[2], st.gpio[0]};
    assign gpio3_alt_pin = st.gpio[7];
    assign gpio2_alt_pin = st.gpio[5];
    assign shift_clock_select = st.sa_route[7:6];
    assign sao_source = st.sa_route[5:4];
    assign dual_playback_select = st.sa_route[3];
    assign capture_source_select = st.sa_route[2];
    assign aux_converter_source_select = st.sa_route[1];
    assign main_converter_source_select = st.sa_route[0];
    // 0 fm, 1 serial input, 2 second dma channel
    assign aux_source = !st.sa_route[1] ? 2'd0 : (st.sa_route[3] ? 2'd2 : 2'd1);
    assign serial_port_reset = st.sa_format[7];
    assign serial_port_test = st.sa_format[6];
    assign slot_position_select = st.sa_format[5];
    assign bit_clocks_per_frame = st.sa_format[4];
    assign sclk_invert = !st.sa_format[3];
    assign frame_sync_invert = !st.sa_format[2];
    assign pulse_frame_mode = st.sa_format[1];

    a_flag_read_clear: assert property (@(posedge mclk) disable iff (rst)
        rd_volume && !vol_up_press |=> !up_flag) else $error("up flag not cleared");
    a_flag_set_wins: assert property (@(posedge mclk) disable iff (rst)
        vol_dn_press |=> dn_flag) else $error("down press lost");
    a_irq_gate: assert property (@(posedge mclk) disable iff (rst)
        vol_up_press && !st.volume[vol_ien_bit] && !ist_flag |=> !ist_flag)
        else $error("irq set while disabled");
    a_ide_route: assert property (@(posedge mclk) disable iff (rst)
        ide_irq_out == (ide_irq_in && fm_enabled_ide())) else $error("ide route");
    a_ee_polarity: assert property (@(posedge mclk) disable iff (rst)
        wr_en && idx == idx_eeprom |=> ee_capable == !$past(wb[ee_cap_bit]))
        else $error("eeprom cap polarity");
    a_pnp_polarity: assert property (@(posedge mclk) disable iff (rst)
        wr_en && idx == idx_eeprom |=> pnp_enabled == $past(wb[pnp_set_bit]))
        else $error("pnp setting polarity");
    a_modem_read: assert property (@(posedge mclk) disable iff (rst)
        rd_load && idx == idx_strap |=> prdata[7] == !$past(st.modem_off))
        else $error("modem read");
    a_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
        rd_load && idx == idx_eeprom |=> prdata[0] == 1'b0 && prdata[31:8] == 24'h0)
        else $error("reserved bits nonzero");
    a_read_wait: assert property (@(posedge mclk) disable iff (rst)
        rd_load |-> !pready ##1 pready) else $error("read wait state");
    a_dp_reset_store: assert property (@(posedge mclk) disable iff (rst)
        wr_en && idx == idx_dp_reset |=> playback_clear == $past(wb[7]))
        else $error("playback reset store");
    a_sclk_polarity: assert property (@(posedge mclk) disable iff (rst)
        wr_en && idx == idx_sa_format |=> sclk_invert == !$past(wb[3]))
        else $error("sclk polarity");
    a_aux_source: assert property (@(posedge mclk) disable iff (rst)
        aux_converter_source_select && dual_playback_select |-> aux_source == 2'd2)
        else $error("aux source");
    a_status_read: assert property (@(posedge mclk) disable iff (rst)
        rd_load && idx == idx_status |=> prdata[7:0] == $past(dp_status))
        else $error("status read");

    c_vol_read: cover property (@(posedge mclk) up_flag ##1 rd_volume);
    c_ee_write: cover property (@(posedge mclk) wr_en && idx == idx_eeprom);
    c_sa_reset: cover property (@(posedge mclk) serial_port_reset);

    function automatic logic fm_enabled_ide();
        return st.fm[7];
    endfunction
endmodule

// File: acir_host.sv
// acir_host: apb master standing in for the host processor.
// assumes read data stands on prdata at the edge where pready is sampled high.
`timescale 1ns/1ps
module acir_host (
    input wire logic mclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // the request stands untouched until pready is sampled high or 64 access-phase cycles pass
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {4'h0, idx[5:0], 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rd = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// File: tb.sv
// tb: self-checking bench, register model kept in a byte array.
// assumes acir_regs and acir_host are compiled first.
`timescale 1ns/1ps
module tb;
    import acir_pkg::*;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, csn_assigned, strap_pin;
    logic vol_up_press, vol_dn_press, ide_irq_in, playback_clear, capture_clear, vol_irq;
    logic master_mute, ee_write_en, ee_cs, ee_clk, ee_din, ee_capable, pnp_enabled;
    logic modem_capable, serial_port_en, ide_irq_out, hi_byte_oe_en, irq34_en, bass_en;
    logic fm_enhanced, fm_external, gpio3_alt_pin, gpio2_alt_pin, dual_playback_select;
    logic capture_source_select, aux_converter_source_select, main_converter_source_select;
    logic serial_port_reset, serial_port_test, slot_position_select, bit_clocks_per_frame;
    logic sclk_invert, frame_sync_invert, pulse_frame_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] dp_status, csn_value, read_port, vfl, rd;
    logic [3:0] pnp_state, test_sel, gpio_oe;
    logic [2:0] ldev_enable;
    logic [1:0] vol_irq_select, shift_clock_select, sao_source, aux_source;
    logic [7:0] r[32];
    int n_errors = 0, n_tests = 0, cyc = 0;
    acir_regs i_acir_regs (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .dp_status, .csn_assigned, .csn_value, .read_port, .pnp_state,
        .ldev_enable, .vol_up_press, .vol_dn_press, .strap_pin, .ide_irq_in,
        .gpio_in(4'h0), .playback_clear, .capture_clear, .test_sel, .vol_irq, .master_mute,
        .vol_irq_select, .ee_write_en, .ee_cs, .ee_clk, .ee_din, .ee_capable, .pnp_enabled,
        .modem_capable, .serial_port_en, .ide_irq_out, .hi_byte_oe_en, .irq34_en, .bass_en,
        .fm_enhanced, .fm_external, .gpio_oe, .gpio3_alt_pin, .gpio2_alt_pin,
        .shift_clock_select, .sao_source, .dual_playback_select, .capture_source_select,
        .aux_converter_source_select, .main_converter_source_select, .aux_source,
        .serial_port_reset, .serial_port_test, .slot_position_select, .bit_clocks_per_frame,
        .sclk_invert, .frame_sync_invert, .pulse_frame_mode);
    acir_host i_acir_host (.mclk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [7:0] wmask(input logic [7:0] i);
        case (i)
            idx_dp_reset: return 8'hc0;
            idx_volume: return 8'h4b;
            idx_eeprom: return 8'hf6;
            idx_strap: return 8'hc0;
            idx_fm: return 8'he7;
            idx_gpio, idx_sa_route, idx_test_sel: return 8'hff;
            idx_sa_format: return 8'hfe;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] rexp(input logic [7:0] i);
        logic [7:0] v;
        v = r[i];
        case (i)
            idx_status: return dp_status;
            idx_pnp: return {csn_assigned, ldev_enable, pnp_state};
            idx_csn: return csn_value;
            idx_rdport: return read_port;
            idx_volume: return v | vfl;
            idx_eeprom: return {v[7:4], 1'b0, ~v[2], ~v[1], 1'b0};
            idx_strap: return {~v[7], v[6], 1'b0, strap_pin, revision_code};
            idx_test_sel: return 8'h00;
            default: return v;
        endcase
    endfunction
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        i_acir_host.xfer(1'b1, i, d, rd);
        r[i] = d & wmask(i);
    endtask
    task automatic rdc(input logic [7:0] i);
        i_acir_host.xfer(1'b0, i, 8'h00, rd);
        chk($sformatf("reg %h", i), rd, rexp(i));
        if (i == idx_volume) vfl = 8'h00;
    endtask
    task automatic outs();
        logic [1:0] aux;
        aux = r[21][1] ? (r[21][3] ? 2'd2 : 2'd1) : 2'd0;
        chk("vol_irq", vol_irq, vfl[2]);
        chk("controls", {playback_clear, capture_clear, ee_write_en, ee_cs, ee_clk, ee_din,
            ee_capable, pnp_enabled, modem_capable, serial_port_en, ide_irq_out, hi_byte_oe_en,
            irq34_en, bass_en, fm_enhanced, fm_external, gpio_oe, gpio3_alt_pin, gpio2_alt_pin,
            shift_clock_select, sao_source, dual_playback_select, capture_source_select,
            aux_converter_source_select, main_converter_source_select, aux_source,
            serial_port_reset, serial_port_test, slot_position_select, bit_clocks_per_frame,
            sclk_invert, frame_sync_invert, pulse_frame_mode, master_mute, vol_irq_select},
            {r[10][7:6], r[17][7:4], ~r[17][2], r[17][1], ~r[18][7], r[18][6],
            r[19][7] & ide_irq_in, r[19][6:5], r[19][2:0], r[20][6], r[20][4], r[20][2],
            r[20][0], r[20][7], r[20][5], r[21][7:4], r[21][3:0], aux, r[22][7:4], ~r[22][3:2],
            r[22][1], r[16][3], r[16][1:0]});
    endtask
    task automatic rin();
        @(posedge mclk);
        dp_status <= 8'($urandom);
        csn_assigned <= 1'($urandom);
        csn_value <= 8'($urandom);
        read_port <= 8'($urandom);
        pnp_state <= 4'($urandom);
        ldev_enable <= 3'($urandom);
        ide_irq_in <= 1'($urandom);
    endtask
    task automatic press(input logic up);
        @(posedge mclk);
        if (up) vol_up_press <= 1'b1;
        else vol_dn_press <= 1'b1;
        @(posedge mclk);
        vol_up_press <= 1'b0;
        vol_dn_press <= 1'b0;
        vfl = vfl | (up ? 8'h20 : 8'h10) | (r[idx_volume][vol_ien_bit] ? 8'h04 : 8'h00);
        @(posedge mclk);
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        foreach (r[k]) r[k] = 8'h00;
        vfl = 8'h00;
    endtask
    task automatic read_all();
        for (int i = 8'h0a; i <= 8'h16; i++) rdc(8'(i));
        rdc(8'h1f);
        outs();
    endtask
    initial begin
        void'($urandom(32'h25ef));
        {rst, vol_up_press, vol_dn_press} = 3'b100;
        strap_pin = 1'($urandom);
        rin();
        do_reset();
        read_all();
        $display("test reset_values done");
        for (int n = 0; n < 8; n++) begin
            for (int i = 8'h0a; i <= 8'h16; i++) wr(8'(i), 8'($urandom));
            wr(8'h1f, 8'hff);
            rin();
            read_all();
        end
        $display("test random_access done");
        wr(idx_volume, 8'h40);
        press(1'b1);
        outs();
        rdc(idx_volume);
        rdc(idx_volume);
        wr(idx_volume, 8'h00);
        press(1'b0);
        rdc(idx_volume);
        outs();
        $display("test volume_buttons done");
        strap_pin <= ~strap_pin;
        do_reset();
        read_all();
        $display("test second_reset done");
        report_and_stop();
    end
endmodule
